// File: hw/cdpm_defs.vh
// Constants for the CPU clock divider and power manager block.
// Assumes inclusion by bare name from design files only.
`ifndef CDPM_DEFS_VH
`define CDPM_DEFS_VH

// APB register byte offsets
`define CDPM_OFF_DIV 12'h000
`define CDPM_OFF_AUX 12'h004
`define CDPM_OFF_POWER_CONTROL_REG 12'h008
`define CDPM_OFF_IEN 12'h00c
`define CDPM_OFF_CFG 12'h010
`define CDPM_OFF_STAT 12'h014

// aux_control_reg fields
`define CDPM_AUX_BOI 5
`define CDPM_AUX_BOD 6
// power_control_reg fields
`define CDPM_POWER_CONTROL_REG_IDL 0
`define CDPM_POWER_CONTROL_REG_PD 1
`define CDPM_POWER_CONTROL_REG_BOF 5
`define CDPM_POWER_CONTROL_REG_POF 4
// irq_enable_reg fields
`define CDPM_IEN_EBO 5
`define CDPM_IEN_EA 7
// user_config_byte fields
`define CDPM_CFG_HALVE_CLOCK_CFG 0
`define CDPM_CFG_WATCHDOG_ENABLE_CFG 1
`define CDPM_CFG_XTAL 2

// Reset values
`define CDPM_RST_DIV 8'h00
`define CDPM_RST_AUX 8'h00
`define CDPM_RST_IEN 8'h00
`define CDPM_RST_CFG 8'h00

// Oscillator stability counts in system clocks
`define CDPM_STAB_XTAL 11'h400
`define CDPM_STAB_RC 11'h100

`endif

// File: hw/cdpm_power_manager.v
// CPU clock divider and power manager: clock enable generation,
// brownout and power-on flags, idle and power-down control, wake logic.
// Assumes an APB master on i_sys_clk and analogue detector levels on pins.
//
// Summary of operation
// [R1] Halve-clock config doubles the CPU period at divider zero: 12 clocks per machine cycle.
// [R2] Divider zero gives oscillator rate, or half with halve-clock set.
// [R3] Divider N of 1..255 divides the CPU clock by 2*(N+1).
// [R4] New divider values take effect on the fly without stalling execution.
// [R5] Brownout resets by default; the select bit makes it an interrupt.
// [R6] Brownout reset holds while the detector reports low supply.
// [R7] Brownout interrupt fires once on the high-to-low supply transition.
// [R8] Brownout interrupt is serviced only with global and own enable set.
// [R9] Brownout sets a sticky flag cleared only by software.
// [R10] Brownout disable bit blocks both reset and interrupt.
// [R11] Power-on detection sets a sticky flag cleared only by software.
// [R12] Idle stops the CPU; peripherals run; enabled irq or reset ends it.
// [R13] Power-down request stops the oscillator and enters power down.
// [R14] Power down ends on reset or enabled interrupt above current priority.
// [R15] Watchdog overflow may reset the device during power down.
// [R16] Brownout configured as interrupt wakes from power down.
// [R17] Wake holds execution 1024 clocks with crystal, 256 otherwise.
// [R18] Brownout, watchdog, comparators, converter run on in power down.
// [R19] Watchdog reset wakes only with enable set; interrupt only with it clear.
// [R20] Brownout wake needs detection enabled; reset or enabled interrupt.
// [R21] Converter wake needs RC clock, converter enabled and interrupt enabled.
// [R22] Keyboard, external and comparator events wake when enabled.
// [R23] Leaving idle or power down clears the matching request bit.
`include "cdpm_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module cdpm_power_manager #(
	parameter DIV_W = 8
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_reset,
	// APB slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire o_pready,
	output reg [31:0] o_prdata,
	output wire o_pslverr,
	// Analogue detectors, asynchronous
	input wire i_brownout_low,
	input wire i_power_on_det,
	// Wake sources from the interrupt system and peripherals
	input wire i_wdt_overflow,
	input wire i_wdt_irq,
	input wire i_ext_reset,
	input wire i_periph_irq,
	input wire i_periph_irq_above_prio,
	input wire i_converter_done,
	input wire i_converter_en,
	input wire i_converter_rc_clock_select,
	input wire i_converter_irq_en,
	// CPU and oscillator controls
	output reg o_cpu_clk_en,
	output wire o_cpu_run,
	output wire o_osc_enable,
	output wire o_brownout_reset,
	output wire o_brownout_irq,
	output wire o_wdt_reset,
	output wire o_analog_keep_alive
);

	// =====================================================================
	// State and registers
	localparam ST_RUN = 4'b0001;
	localparam ST_IDLE = 4'b0010;
	localparam ST_PDOWN = 4'b0100;
	localparam ST_WAKE = 4'b1000;

	reg [3:0] state;
	reg [3:0] next_state;
	reg [DIV_W-1:0] cpu_clock_divider;
	reg [7:0] aux_control_reg;
	reg [7:0] irq_enable_reg;
	reg [7:0] user_config_byte;
	reg idle_request;
	reg power_down_request;
	reg brownout_flag;
	reg power_on_flag;
	reg bo_irq_pend;
	reg [DIV_W:0] div_cnt;
	reg [10:0] stab_cnt;
	reg [2:0] bo_sync;
	reg [2:0] po_sync;
	reg bo_level;
	reg po_level;

	wire halve_clock_cfg = user_config_byte[`CDPM_CFG_HALVE_CLOCK_CFG];
	wire watchdog_enable_cfg = user_config_byte[`CDPM_CFG_WATCHDOG_ENABLE_CFG];
	wire brownout_irq_select = aux_control_reg[`CDPM_AUX_BOI];
	wire brownout_disable = aux_control_reg[`CDPM_AUX_BOD];
	wire global_irq_enable = irq_enable_reg[`CDPM_IEN_EA];
	wire brownout_irq_enable = irq_enable_reg[`CDPM_IEN_EBO];

	// =====================================================================
	// APB access
	wire wr = i_psel & i_penable & i_pwrite;
	wire rd_sel = i_psel & ~i_pwrite;

	function hit;
		input [11:0] addr;
		input [11:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	wire unmapped = ~(hit(i_paddr, `CDPM_OFF_DIV) |
		hit(i_paddr, `CDPM_OFF_AUX) | hit(i_paddr, `CDPM_OFF_POWER_CONTROL_REG) |
		hit(i_paddr, `CDPM_OFF_IEN) | hit(i_paddr, `CDPM_OFF_CFG) |
		hit(i_paddr, `CDPM_OFF_STAT));

	// Zero wait states; unmapped addresses answer with an error
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & unmapped;

	// Per-register write strobes, qualified by the access phase
	wire wr_div = wr & hit(i_paddr, `CDPM_OFF_DIV);
	wire wr_aux = wr & hit(i_paddr, `CDPM_OFF_AUX);
	wire wr_power_control_reg = wr & hit(i_paddr, `CDPM_OFF_POWER_CONTROL_REG);
	wire wr_ien = wr & hit(i_paddr, `CDPM_OFF_IEN);
	wire wr_cfg = wr & hit(i_paddr, `CDPM_OFF_CFG);

	// =====================================================================
	// Detector synchronisers: a change counts when stages two and three agree
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			bo_sync <= 3'h0;
			po_sync <= 3'h0;
			bo_level <= 1'b0;
			po_level <= 1'b0;
		end else begin
			bo_sync <= {bo_sync[1:0], i_brownout_low};
			po_sync <= {po_sync[1:0], i_power_on_det};
			if (bo_sync[1] == bo_sync[2])
				bo_level <= bo_sync[2];
			if (po_sync[1] == po_sync[2])
				po_level <= po_sync[2];
		end
	end

	// Brownout path stays live in every mode, including power down
	wire bo_active = bo_level & ~brownout_disable; // [R10] [R18]
	wire bo_fall_edge = bo_sync[1] & bo_sync[2] & ~bo_level;
	wire bo_event = bo_fall_edge & ~brownout_disable;
	assign o_brownout_reset = bo_active & ~brownout_irq_select; // [R5] [R6]
	// [R8] Only serviced with both enables set
	assign o_brownout_irq = bo_irq_pend & global_irq_enable &
		brownout_irq_enable;
	assign o_analog_keep_alive = 1'b1; // [R18]

	// =====================================================================
	// Wake qualification
	wire irq_wake = i_periph_irq & i_periph_irq_above_prio; // [R14] [R22]
	wire adc_wake = i_converter_done & i_converter_en &
		i_converter_rc_clock_select & i_converter_irq_en; // [R21]
	wire wdt_irq_wake = i_wdt_irq & ~watchdog_enable_cfg; // [R19]
	assign o_wdt_reset = i_wdt_overflow & watchdog_enable_cfg; // [R15] [R19]
	wire bo_irq_wake = bo_event & brownout_irq_select &
		brownout_irq_enable; // [R16] [R20]
	wire any_reset = i_ext_reset | o_wdt_reset | o_brownout_reset; // [R20]
	wire idle_wake = (i_periph_irq & global_irq_enable) | o_brownout_irq |
		adc_wake | wdt_irq_wake; // [R12]
	wire pd_wake = irq_wake | adc_wake | wdt_irq_wake | bo_irq_wake;

	// Exit conditions, repeating those of the state change, for the request-bit clear
	wire leave_idle = (state == ST_IDLE) & (idle_wake | any_reset);
	wire leave_wake = (state == ST_WAKE) & (stab_cnt == 11'h001);

	wire [10:0] stab_len = user_config_byte[`CDPM_CFG_XTAL] ?
		`CDPM_STAB_XTAL : `CDPM_STAB_RC;

	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (power_down_request)
					next_state = ST_PDOWN; // [R13]
				else if (idle_request)
					next_state = ST_IDLE; // [R12]
			end
			ST_IDLE: begin
				if (idle_wake | any_reset)
					next_state = ST_RUN; // [R12]
			end
			ST_PDOWN: begin
				if (pd_wake | any_reset)
					next_state = ST_WAKE; // [R14]
			end
			ST_WAKE: begin
				if (stab_cnt == 11'h001)
					next_state = ST_RUN; // [R17]
			end
			default: next_state = ST_RUN;
		endcase
	end

	assign o_osc_enable = (state != ST_PDOWN); // [R13] [R17]
	assign o_cpu_run = (state == ST_RUN);

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			state <= ST_RUN;
			stab_cnt <= 11'h000;
		end else begin
			state <= next_state;
			if (state == ST_PDOWN)
				stab_cnt <= stab_len; // [R17]
			else if (state == ST_WAKE)
				stab_cnt <= stab_cnt - 11'h001;
		end
	end

	// =====================================================================
	// CPU clock enable: terminal compared every cycle, so rate changes apply at once
	wire [DIV_W:0] div_term = (cpu_clock_divider == {DIV_W{1'b0}}) ?
		{{DIV_W{1'b0}}, halve_clock_cfg} : // [R1] [R2]
		{cpu_clock_divider, 1'b1}; // [R3]

	reg [DIV_W:0] next_div_cnt;
	reg next_cpu_clk_en;

	// A count already past a smaller new terminal ends the period at once,
	// so a rate change never stalls the CPU for a counter wrap.
	always @* begin
		if (div_cnt >= div_term) begin // [R4]
			next_div_cnt = {(DIV_W+1){1'b0}};
			next_cpu_clk_en = 1'b1;
		end else begin
			next_div_cnt = div_cnt + 1'b1;
			next_cpu_clk_en = 1'b0;
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			div_cnt <= {(DIV_W+1){1'b0}};
			o_cpu_clk_en <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			o_cpu_clk_en <= next_cpu_clk_en;
		end
	end

	// =====================================================================
	// Software registers and sticky flags
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			cpu_clock_divider <= `CDPM_RST_DIV;
			aux_control_reg <= `CDPM_RST_AUX;
			irq_enable_reg <= `CDPM_RST_IEN;
			user_config_byte <= `CDPM_RST_CFG;
			idle_request <= 1'b0;
			power_down_request <= 1'b0;
			brownout_flag <= 1'b0;
			power_on_flag <= 1'b0;
			bo_irq_pend <= 1'b0;
		end else begin
			if (wr_div)
				cpu_clock_divider <= i_pwdata[DIV_W-1:0]; // [R4]
			if (wr_aux)
				aux_control_reg <= i_pwdata[7:0];
			if (wr_ien)
				irq_enable_reg <= i_pwdata[7:0];
			if (wr_cfg)
				user_config_byte <= i_pwdata[7:0];
			if (wr_power_control_reg) begin
				idle_request <= i_pwdata[`CDPM_POWER_CONTROL_REG_IDL];
				power_down_request <= i_pwdata[`CDPM_POWER_CONTROL_REG_PD];
				// Write zero clears; hardware set below wins
				brownout_flag <= brownout_flag &
					i_pwdata[`CDPM_POWER_CONTROL_REG_BOF];
				power_on_flag <= power_on_flag &
					i_pwdata[`CDPM_POWER_CONTROL_REG_POF];
			end
			if (leave_idle)
				idle_request <= 1'b0; // [R23]
			if (leave_wake)
				power_down_request <= 1'b0; // [R23]
			if (bo_event | bo_active)
				brownout_flag <= 1'b1; // [R9]
			if (po_level)
				power_on_flag <= 1'b1; // [R11]
			// Pending interrupt taken as once-only pulse on the edge
			if (bo_event & brownout_irq_select)
				bo_irq_pend <= 1'b1; // [R7]
			else if (o_brownout_irq | ~brownout_irq_select)
				bo_irq_pend <= 1'b0;
		end
	end

	// =====================================================================
	// Read data: latched in the setup cycle, held through the access phase
	reg [31:0] next_prdata;

	always @* begin
		next_prdata = o_prdata;
		if (rd_sel & ~i_penable) begin
			next_prdata = 32'h00000000;
			if (hit(i_paddr, `CDPM_OFF_DIV))
				next_prdata[DIV_W-1:0] = cpu_clock_divider;
			if (hit(i_paddr, `CDPM_OFF_AUX))
				next_prdata[7:0] = aux_control_reg;
			if (hit(i_paddr, `CDPM_OFF_IEN))
				next_prdata[7:0] = irq_enable_reg;
			if (hit(i_paddr, `CDPM_OFF_CFG))
				next_prdata[7:0] = user_config_byte;
			if (hit(i_paddr, `CDPM_OFF_POWER_CONTROL_REG)) begin
				next_prdata[`CDPM_POWER_CONTROL_REG_IDL] = idle_request;
				next_prdata[`CDPM_POWER_CONTROL_REG_PD] = power_down_request;
				next_prdata[`CDPM_POWER_CONTROL_REG_BOF] = brownout_flag;
				next_prdata[`CDPM_POWER_CONTROL_REG_POF] = power_on_flag;
			end
			if (hit(i_paddr, `CDPM_OFF_STAT))
				next_prdata[5:0] = {bo_irq_pend, po_level, bo_level,
					state[2:0]};
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_reset)
			o_prdata <= 32'h00000000;
		else
			o_prdata <= next_prdata;
	end

endmodule
`default_nettype wire

// File: sim/cdpm_far_model.sv
// Interrupt side model: raises one enabled peripheral request on command.
// Assumes the request is taken once the CPU is seen running again.
`timescale 1ns/1ps
`default_nettype none
module cdpm_far_model (
	// Clock
	input wire logic i_sys_clk,
	// From the block and the bench
	input wire logic i_cpu_run,
	input wire logic i_raise,
	// To the block
	output logic o_irq,
	output logic o_above
);
	initial o_irq = 1'b0;
	// Serviced as soon as the CPU runs, so a held command cannot re-wake
	always @(posedge i_sys_clk) begin
		if (i_cpu_run)
			o_irq <= 1'b0;
		else if (i_raise)
			o_irq <= 1'b1;
	end
	assign o_above = o_irq;
endmodule
`default_nettype wire

// File: sim/cdpm_chk_sva.sv
// Port checker for the power manager.
// Assumes a bind onto the top module with matching port names.
`timescale 1ns/1ps
`default_nettype none
module cdpm_chk (
	input wire i_sys_clk,
	input wire i_reset,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire i_brownout_low,
	input wire i_wdt_overflow,
	input wire o_cpu_run,
	input wire o_osc_enable,
	input wire o_brownout_reset,
	input wire o_brownout_irq,
	input wire o_wdt_reset,
	input wire o_analog_keep_alive
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// ==========================================
	// Properties
	property p_wdt; o_wdt_reset |-> i_wdt_overflow; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset");
	// Synchroniser depth leaves six quiet cycles enough
	property p_bo_quiet; !i_brownout_low [*6] |-> !o_brownout_reset;
	endproperty
	a_bo_quiet: assert property (p_bo_quiet) else $error("bo reset");
	property p_bo_excl; o_brownout_irq |-> !o_brownout_reset; endproperty
	a_bo_excl: assert property (p_bo_excl) else $error("bo both");
	property p_osc; !o_osc_enable |-> !o_cpu_run; endproperty
	a_osc: assert property (p_osc) else $error("run without osc");
	property p_pd_entry; i_psel && i_penable && i_pwrite &&
		i_paddr == 12'h008 && i_pwdata[1] |-> ##2 !o_osc_enable;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("pd entry");
	property p_hold; $rose(o_osc_enable) |-> !o_cpu_run [*8]; endproperty
	a_hold: assert property (p_hold) else $error("early run");
	// Wake time runs past a delay range, so it is counted here instead
	logic waking;
	logic [10:0] wake_cnt;
	always @(posedge i_sys_clk) begin
		if (i_reset || o_cpu_run) begin
			waking <= 1'b0;
			wake_cnt <= 11'h000;
		end else begin
			if (!o_osc_enable)
				waking <= 1'b1;
			if (waking && o_osc_enable && wake_cnt != 11'h7ff)
				wake_cnt <= wake_cnt + 11'h001;
		end
	end
	property p_bound; wake_cnt <= 11'h408; endproperty
	a_bound: assert property (p_bound) else $error("late run");
	property p_keep; o_analog_keep_alive; endproperty
	a_keep: assert property (p_keep) else $error("analog off");
endmodule
bind cdpm_power_manager cdpm_chk u_chk (.*);
`default_nettype wire

// File: sim/tb_clock_divider_power_manager.sv
// Self-checking bench for the clock divider and power manager.
// Assumes zero-wait APB and stability counted in system clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_clock_divider_power_manager;
	logic i_sys_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0;
	logic i_pwrite = 0, i_brownout_low = 0, i_power_on_det = 0;
	logic i_wdt_overflow = 0, i_wdt_irq = 0, i_ext_reset = 0, raise = 0;
	logic i_converter_done = 0, i_converter_en = 0;
	logic i_converter_rc_clock_select = 0, i_converter_irq_en = 0;
	logic [11:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0;
	logic [32:0] q[$];
	logic [32:0] e;
	wire o_pready, o_pslverr, o_cpu_clk_en, o_cpu_run, o_osc_enable;
	wire o_brownout_reset, o_brownout_irq, o_wdt_reset, o_analog_keep_alive;
	wire i_periph_irq, i_periph_irq_above_prio;
	wire [31:0] o_prdata;
	wire [3:0] mon = {o_brownout_reset, o_brownout_irq, o_cpu_run,
		o_cpu_clk_en};
	int bad_count = 0, n_checks = 0, c, i, n;
	integer seed = 32'hc4f1d984;
	cdpm_power_manager DUT (.*);
	cdpm_far_model FAR (.i_sys_clk(i_sys_clk), .i_cpu_run(o_cpu_run),
		.i_raise(raise), .o_irq(i_periph_irq),
		.o_above(i_periph_irq_above_prio));
	initial forever #2.5 i_sys_clk = ~i_sys_clk;
	// ==========================================
	// Tasks
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge i_sys_clk);
	endtask
	// Bounded wait for one monitored output; c counts edges before the one that sees it
	task automatic wt(input int b, input int lim);
		for (c = 0; c < lim; c++) begin
			@(posedge i_sys_clk);
			if (mon[b] === 1'b1)
				break;
		end
		if (c == lim) begin
			bad_count++;
			report_and_stop;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge i_sys_clk);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_sys_clk);
		i_penable <= 1;
		for (k = 0; k < 50; k++) begin
			@(posedge i_sys_clk);
			if (o_pready === 1'b1)
				break;
		end
		if (k == 50)
			chk(0, "pready timeout");
		i_psel <= 0;
		i_penable <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic er);
		q.push_back({er, x});
		apb(0, a, 0);
	endtask
	// Three pulses seen, the last gap is the settled period
	task automatic per(input int x);
		wt(0, 600);
		wt(0, 600);
		wt(0, 600);
		chk(c + 1 == x, "cpu clock period");
	endtask
	// ==========================================
	// Read monitor: oldest note against the completed read
	always @(posedge i_sys_clk) begin
		if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite) begin
			e = q.pop_front();
			chk({o_pslverr, o_prdata} === e, "read data");
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		tick(5);
		i_reset <= 0;
		foreach (mon[j]) rd(12'h004 * j, 0, 0);
		rd(12'h010, 0, 0);
		rd(12'h018, 0, 1);
		per(1);
		apb(1, 12'h010, 1);
		per(2);
		apb(1, 12'h010, 0);
		for (i = 0; i < 3; i++) begin
			n = i == 0 ? 1 : i == 1 ? 255 : 1 + $unsigned($random(seed)) % 255;
			apb(1, 12'h000, n);
			per(2 * (n + 1));
		end
		apb(1, 12'h000, 0);
		i_power_on_det <= 1;
		tick(8);
		i_power_on_det <= 0;
		tick(4);
		rd(12'h008, 32'h10, 0);
		apb(1, 12'h008, 0);
		apb(1, 12'h00c, 32'ha0);
		i_brownout_low <= 1;
		wt(3, 10);
		tick(10);
		chk(o_brownout_reset === 1 && o_brownout_irq === 0, "bo reset");
		rd(12'h008, 32'h20, 0);
		i_brownout_low <= 0;
		tick(8);
		apb(1, 12'h004, 32'h20);
		apb(1, 12'h008, 0);
		i_brownout_low <= 1;
		wt(2, 10);
		tick(3);
		chk(o_brownout_irq === 0 && o_brownout_reset === 0, "bo irq");
		i_brownout_low <= 0;
		tick(6);
		apb(1, 12'h00c, 32'h20);
		i_brownout_low <= 1;
		tick(10);
		chk(o_brownout_irq === 0, "irq without global enable");
		i_brownout_low <= 0;
		tick(6);
		apb(1, 12'h00c, 32'ha0);
		apb(1, 12'h004, 32'h60);
		i_brownout_low <= 1;
		tick(10);
		chk(o_brownout_irq === 0 && o_brownout_reset === 0, "bo off");
		apb(1, 12'h004, 32'h40);
		tick(2);
		chk(o_brownout_reset === 0, "bo reset while disabled");
		i_brownout_low <= 0;
		tick(6);
		for (i = 0; i < 2; i++) begin
			apb(1, 12'h010, 2 * i);
			i_wdt_overflow <= 1;
			@(posedge i_sys_clk);
			chk(o_wdt_reset === i[0], "watchdog reset");
			i_wdt_overflow <= 0;
		end
		apb(1, 12'h010, 0);
		apb(1, 12'h008, 0);
		apb(1, 12'h008, 2);
		tick(2);
		chk(o_osc_enable === 0 && o_cpu_run === 0, "power down");
		raise <= 1;
		wt(1, 1100);
		chk(c >= 256 && c <= 264, "wake hold");
		raise <= 0;
		rd(12'h008, 0, 0);
		apb(1, 12'h008, 1);
		tick(2);
		chk(o_cpu_run === 0 && o_osc_enable === 1, "idle");
		raise <= 1;
		wt(1, 6);
		raise <= 0;
		rd(12'h008, 0, 0);
		tick(2);
		report_and_stop;
	end
endmodule
`default_nettype wire
